// ==== video_forwarding_control.sv ====
// Forwarding engine merging two receive ports onto a CSI output
`timescale 1ns/1ps
`default_nettype none
module video_forwarding_control
   import fwd_ctrl_pkg::*;
#(
   parameter int DW = 32,
   parameter int WAIT_LIMIT = ALIGN_WAIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   output logic o_irq,
   // Receive port line buffers
   input wire logic [1:0] i_rx_valid,
   input wire logic [DW-1:0] i_rx0_data,
   input wire logic [DW-1:0] i_rx1_data,
   input wire logic [1:0] i_rx_last,
   input wire logic [1:0] i_rx_long,
   input wire logic [1:0] i_rx_frame_end,
   output logic [1:0] o_rx_ready,
   // CSI output port 0
   output logic o_csi0_valid,
   output logic [DW-1:0] o_csi0_data,
   output logic o_csi0_last,
   output logic o_csi0_src,
   input wire logic i_csi0_ready,
   // CSI output port 1, used in replicate mode
   output logic o_csi1_valid,
   output logic [DW-1:0] o_csi1_data,
   output logic o_csi1_last,
   input wire logic i_csi1_ready
);
   logic [7:0] port_ctrl;
   logic [7:0] policy_ctrl;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic lost_flag;
   logic synced;
   logic frame_ok;
   fwd_state_t state;
   fwd_state_t next_state;
   logic src;
   logic [1:0] pending;
   logic group_fe;
   logic group_sync;
   logic [DW-1:0] rx_data [2];
   logic [1:0] take_v;

   //------------------------------------------------------------
   // Control decode
   //------------------------------------------------------------
   // Port enables, policy and derived conditions
   wire [1:0] en = ~{port_ctrl[PORT1_OFF_BIT], port_ctrl[PORT0_OFF_BIT]};
   wire [1:0] policy = policy_ctrl[POLICY_LO_BIT +: 2];
   wire sync_on = (policy != POLICY_OFF);
   wire rot_on = policy_ctrl[ROT_EN_BIT] && !sync_on;
   wire concat = (policy == POLICY_CONCAT);
   wire ready_eff = policy_ctrl[SEND_READY_BIT] && !concat;
   wire rep_on = policy_ctrl[REPLICATE_BIT];
   wire [1:0] have = i_rx_valid & en;
   wire all_have = (en != 2'h0) && (have == en);
   wire [1:0] long_have = have & i_rx_long;

   // Per-port data gather and take strobes
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_port
         assign take_v[gp] = o_rx_ready[gp] & i_rx_valid[gp];
      end
   endgenerate
   assign rx_data[0] = i_rx0_data;
   assign rx_data[1] = i_rx1_data;

   //------------------------------------------------------------
   // Source choice
   //------------------------------------------------------------
   // Rotating arbiter requests depend on the active policy
   logic [1:0] grant;
   wire [1:0] rot_req = sync_on ? long_have : have;
   wire start_sync = sync_on && all_have;
   wire start_ready = sync_on && ready_eff && (long_have != 2'h0) && !all_have;
   wire start_free = !sync_on && (have != 2'h0);
   wire start_any = (state == ST_IDLE) && (start_sync || start_ready || start_free);
   wire [1:0] turn_left = pending & en;

   rot_pick u_pick (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_req(rot_on ? rot_req : (rot_req & (rot_req[0] ? 2'h1 : 2'h2))),
      .i_advance(start_any && !start_sync),
      .o_grant(grant)
   );

   //------------------------------------------------------------
   // Transfer path
   //------------------------------------------------------------
   // Output accepts when both active CSI ports can take data
   wire tx_ready = i_csi0_ready && (!rep_on || i_csi1_ready);
   wire take = |take_v;
   wire take_last = |(take_v & i_rx_last);
   wire next_tx_valid = take || (o_csi0_valid && !tx_ready);
   // Concatenated group: first line's end is hidden so lines join
   wire hide_last = group_sync && concat && (turn_left & ~(2'h1 << src)) != 2'h0;
   wire next_last = i_rx_last[src] && !hide_last;

   // Engine state transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_any) begin
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (take && take_last) begin
               next_state = ST_TURN;
            end
         end
         ST_TURN: begin
            next_state = (turn_left != 2'h0) ? ST_SEND : ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State, source and group bookkeeping
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         src <= 1'b0;
         pending <= 2'h0;
         group_fe <= 1'b0;
         group_sync <= 1'b0;
      end else begin
         state <= next_state;
         if (start_any && start_sync) begin
            src <= !en[0];
            pending <= en;
            group_fe <= &(i_rx_frame_end | ~en);
            group_sync <= 1'b1;
         end else if (start_any) begin
            src <= grant[1];
            pending <= grant;
            group_fe <= 1'b0;
            group_sync <= 1'b0;
         end else if (state == ST_SEND && take && take_last) begin
            pending <= pending & ~(2'h1 << src);
         end else if (state == ST_TURN && turn_left != 2'h0) begin
            src <= !turn_left[0];
         end
      end
   end

   // Registered ready toward the selected receive port
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rx_ready <= 2'h0;
      end else if (next_state == ST_SEND && !next_tx_valid && !(take && take_last)) begin
         o_rx_ready <= (state == ST_IDLE) ? (start_sync ? (en[0] ? 2'h1 : 2'h2) : grant)
            : ((state == ST_TURN) ? (turn_left[0] ? 2'h1 : 2'h2) : (2'h1 << src));
      end else begin
         o_rx_ready <= 2'h0;
      end
   end

   // Output word register, mirrored onto CSI port 1 in replicate mode
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_csi0_valid <= 1'b0;
         o_csi0_data <= '0;
         o_csi0_last <= 1'b0;
         o_csi0_src <= 1'b0;
         o_csi1_valid <= 1'b0;
         o_csi1_data <= '0;
         o_csi1_last <= 1'b0;
      end else begin
         o_csi0_valid <= next_tx_valid;
         o_csi1_valid <= next_tx_valid && rep_on;
         if (take) begin
            o_csi0_data <= rx_data[src];
            o_csi0_last <= next_last;
            o_csi0_src <= src;
            o_csi1_data <= rep_on ? rx_data[src] : '0;
            o_csi1_last <= rep_on && next_last;
         end
      end
   end

   //------------------------------------------------------------
   // Synchronization status
   //------------------------------------------------------------
   // Waiting for alignment too long after a good frame is a loss
   logic wait_hit;
   wire group_done = (state == ST_SEND) && take && take_last && (pending == (2'h1 << src));
   wire frame_done = group_done && group_sync && group_fe;
   wire lost_event = wait_hit && frame_ok;
   wire rd_status = i_rd && (i_addr == ADDR_FWD_STATUS);

   wait_timer #(
      .LIMIT(WAIT_LIMIT)
   ) u_wait (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(sync_on && state == ST_IDLE && have != 2'h0 && !all_have),
      .o_hit(wait_hit)
   );

   // Synced, good-frame and loss flags; a new loss beats the read clear
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         synced <= 1'b0;
         frame_ok <= 1'b0;
         lost_flag <= 1'b0;
      end else begin
         if (!sync_on || lost_event) begin
            synced <= 1'b0;
            frame_ok <= 1'b0;
         end else if (frame_done) begin
            synced <= 1'b1;
            frame_ok <= 1'b1;
         end
         if (lost_event) begin
            lost_flag <= 1'b1;
         end else if (rd_status) begin
            lost_flag <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // Register port
   //------------------------------------------------------------
   // Write decode
   wire wr_port = i_wr && (i_addr == ADDR_PORT_CTRL);
   wire wr_policy = i_wr && (i_addr == ADDR_POLICY_CTRL);
   wire wr_irq_clr = i_wr && (i_addr == ADDR_IRQ_STATUS);
   wire wr_irq_mask = i_wr && (i_addr == ADDR_IRQ_MASK);
   wire [1:0] irq_event = {frame_done, lost_event};
   wire [1:0] next_irq_status = irq_event | (irq_status & ~(wr_irq_clr ? i_wr_data[1:0] : 2'h0));

   // Control registers keep only their defined bits
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         port_ctrl <= PORT_CTRL_RESET;
         policy_ctrl <= POLICY_CTRL_RESET;
         irq_mask <= IRQ_RESET;
      end else begin
         if (wr_port) begin
            port_ctrl <= i_wr_data & PORT_CTRL_MASK;
         end
         if (wr_policy) begin
            policy_ctrl <= i_wr_data & POLICY_CTRL_MASK;
         end
         if (wr_irq_mask) begin
            irq_mask <= i_wr_data[1:0];
         end
      end
   end

   // Sticky interrupt status and the level interrupt line
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_status <= IRQ_RESET;
         o_irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         o_irq <= |(next_irq_status & irq_mask);
      end
   end

   // Read mux, answered one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      case (i_addr)
         ADDR_PORT_CTRL: rd_mux = port_ctrl;
         ADDR_POLICY_CTRL: rd_mux = policy_ctrl;
         ADDR_FWD_STATUS: rd_mux = {5'h00, lost_flag, 1'b0, synced};
         ADDR_IRQ_STATUS: rd_mux = {6'h00, irq_status};
         ADDR_IRQ_MASK: rd_mux = {6'h00, irq_mask};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rd_data <= 8'h00;
      end else begin
         o_rd_data <= i_rd ? rd_mux : 8'h00;
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   chk_port0_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && port_ctrl[PORT0_OFF_BIT]) |=> !(state == ST_SEND && !src))
      else $error("disabled port 0 was started");
   chk_port1_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && port_ctrl[PORT1_OFF_BIT]) |=> !(state == ST_SEND && src))
      else $error("disabled port 1 was started");
   chk_replicate_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_csi1_valid |-> (o_csi0_valid && o_csi1_data == o_csi0_data && o_csi1_last == o_csi0_last))
      else $error("replicated output differs from port 0");
   chk_sync_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && sync_on && !ready_eff && !all_have) |=> state == ST_IDLE)
      else $error("synchronized line sent before all ports ready");
   chk_ready_sends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && sync_on && ready_eff && long_have != 2'h0) |=> state == ST_SEND)
      else $error("as-available line was held");
   chk_concat_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && concat && !all_have) |=> state == ST_IDLE)
      else $error("as-available active in concatenation");
   chk_short_waits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && sync_on && long_have == 2'h0 && !all_have) |=> state == ST_IDLE)
      else $error("short packet sent unsynchronized");
   chk_rotate_free: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && rot_on && have != 2'h0) |=> (state == ST_SEND) [*1] ##1 1'b1)
      else $error("round robin waited for alignment");
   chk_lost_needs_frame: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(lost_flag) |-> $past(frame_ok))
      else $error("loss flagged with no prior synced frame");
   chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_PORT_CTRL) |=> (o_rd_data[3:0] == 4'h0 && o_rd_data[7:6] == 2'h0))
      else $error("reserved control bits read nonzero");
endmodule // video_forwarding_control
`default_nettype wire

// ==== fwd_ctrl_pkg.sv ====
// Shared constants for the video forwarding control block
//------------------------------------------------------------
// Function
// - Port 0 disable bit 4, resets set
// - Port 1 disable bit 5, resets set
// - Replicate bit 7 copies CSI0 onto CSI1
// - Synchronized mode waits for all enabled ports
// - As-available bit 6 sends lines when ready
// - As-available ignored in line concatenation mode
// - As-available affects long packets only
// - Policy field bits 3:2 selects sync mode
// - Bit 0 enables round robin, resets set
// - Round robin never aligns ports
// - Failure flag needs prior good frame, read-clears
//------------------------------------------------------------
package fwd_ctrl_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_PORT_CTRL = 8'h20;
   localparam logic [7:0] ADDR_POLICY_CTRL = 8'h21;
   localparam logic [7:0] ADDR_FWD_STATUS = 8'h22;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;
   // Field positions
   localparam int PORT0_OFF_BIT = 4;
   localparam int PORT1_OFF_BIT = 5;
   localparam int ROT_EN_BIT = 0;
   localparam int POLICY_LO_BIT = 2;
   localparam int SEND_READY_BIT = 6;
   localparam int REPLICATE_BIT = 7;
   localparam int SYNCED_BIT = 0;
   localparam int LOST_BIT = 2;
   // Writable bits and reset values
   localparam logic [7:0] PORT_CTRL_MASK = 8'h30;
   localparam logic [7:0] POLICY_CTRL_MASK = 8'hCD;
   localparam logic [7:0] PORT_CTRL_RESET = 8'h30;
   localparam logic [7:0] POLICY_CTRL_RESET = 8'h01;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // Interrupt event bits
   localparam int IRQ_LOST_BIT = 0;
   localparam int IRQ_FRAME_BIT = 1;
   // Synchronized policy encodings
   localparam logic [1:0] POLICY_OFF = 2'h0;
   localparam logic [1:0] POLICY_BASIC = 2'h1;
   localparam logic [1:0] POLICY_INTERLEAVE = 2'h2;
   localparam logic [1:0] POLICY_CONCAT = 2'h3;
   // Alignment wait limit before a loss is declared
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ALIGN_WAIT_NS = 10000;
   localparam int ALIGN_WAIT_CYC = (ALIGN_WAIT_NS * 1000) / CLK_PERIOD_PS;
   // Engine states, Gray along idle -> send -> turn
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_TURN = 2'b11
   } fwd_state_t;
endpackage

// ==== rot_pick.sv ====
// Two-way rotating arbiter for forwarding sources
`timescale 1ns/1ps
`default_nettype none
module rot_pick (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_req,
   input wire logic i_advance,
   output logic [1:0] o_grant
);
   logic last;
   //------------------------------------------------------------
   // Grant selection
   //------------------------------------------------------------
   // Favour the port not served last when both ask
   assign o_grant = (i_req == 2'h3) ? (last ? 2'h1 : 2'h2) : i_req;
   //------------------------------------------------------------
   // Turn memory
   //------------------------------------------------------------
   // Remember which port won most recently
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         last <= 1'b1;
      end else if (i_advance && (o_grant != 2'h0)) begin
         last <= o_grant[1];
      end
   end
endmodule // rot_pick
`default_nettype wire

// ==== wait_timer.sv ====
// Cycle counter that flags a wait running past its limit
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
   parameter int LIMIT = 2000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   output logic o_hit
);
   logic [15:0] count;
   //------------------------------------------------------------
   // Counter
   //------------------------------------------------------------
   // Counts while waiting, one pulse when the limit is reached
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_run) begin
         count <= 16'h0000;
         o_hit <= 1'b0;
      end else begin
         o_hit <= (count == 16'(LIMIT - 1));
         if (count != 16'(LIMIT)) begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule // wait_timer
`default_nettype wire

// ==== csi_sink.sv ====
// Downstream CSI-2 receiver model that takes and logs output words
`timescale 1ns/1ps
`default_nettype none
module csi_sink #(
   parameter int DW = 32
) (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic i_peer_ready,
   input wire logic i_valid,
   input wire logic [DW-1:0] i_data,
   input wire logic [1:0] i_tag,
   output logic o_ready
);
   logic [DW-1:0] got[$];
   logic [1:0] tag[$];
   logic flip = 1'b0;
   // Ready every cycle, or every other cycle while slowed
   assign o_ready = !i_slow || flip;
   // Log each word that leaves; in replicate mode both receivers must accept
   always @(posedge i_clk) begin
      flip <= !flip;
      if (i_valid && o_ready && i_peer_ready) begin
         got.push_back(i_data);
         tag.push_back(i_tag);
      end
   end
endmodule // csi_sink
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the video forwarding control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fwd_ctrl_pkg::*;
   localparam int DW = 32;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic i_clk, i_rst_n, i_wr, i_rd, o_irq, slow0, slow1, multi;
   logic [7:0] i_addr, i_wr_data, o_rd_data;
   logic [1:0] i_rx_long, i_rx_end, o_rx_ready, rx_valid, rx_last;
   logic [DW-1:0] rx0_data, rx1_data, o_csi0_data, o_csi1_data;
   logic o_csi0_valid, o_csi0_last, o_csi0_src, o_csi1_valid, o_csi1_last, rdy0, rdy1;
   int cnt0, cnt1, err_count, n_tests;
   row_t rows[11];
   //------------------------------------------------------------
   // Receive line buffers: words counted down, single-word packets unless multi is set
   //------------------------------------------------------------
   assign rx_valid = {cnt1 > 0, cnt0 > 0};
   assign rx0_data = {16'h0000, cnt0[15:0]};
   assign rx1_data = {16'h0001, cnt1[15:0]};
   // Multi-word packets end on the last counted word
   assign rx_last = {!multi || cnt1 == 1, !multi || cnt0 == 1};
   always @(posedge i_clk) begin
      if (o_rx_ready[0] && rx_valid[0]) cnt0 <= cnt0 - 1;
      if (o_rx_ready[1] && rx_valid[1]) cnt1 <= cnt1 - 1;
   end
   video_forwarding_control #(.DW(DW), .WAIT_LIMIT(8)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_irq(o_irq),
      .i_rx_valid(rx_valid), .i_rx0_data(rx0_data), .i_rx1_data(rx1_data),
      .i_rx_last(rx_last), .i_rx_long(i_rx_long), .i_rx_frame_end(i_rx_end),
      .o_rx_ready(o_rx_ready), .o_csi0_valid(o_csi0_valid), .o_csi0_data(o_csi0_data),
      .o_csi0_last(o_csi0_last), .o_csi0_src(o_csi0_src), .i_csi0_ready(rdy0),
      .o_csi1_valid(o_csi1_valid), .o_csi1_data(o_csi1_data),
      .o_csi1_last(o_csi1_last), .i_csi1_ready(rdy1));
   csi_sink #(.DW(DW)) sink0 (.i_clk(i_clk), .i_slow(slow0),
      .i_peer_ready(!o_csi1_valid || rdy1), .i_valid(o_csi0_valid),
      .i_data(o_csi0_data), .i_tag({o_csi0_src, o_csi0_last}), .o_ready(rdy0));
   csi_sink #(.DW(DW)) sink1 (.i_clk(i_clk), .i_slow(slow1),
      .i_peer_ready(rdy0), .i_valid(o_csi1_valid),
      .i_data(o_csi1_data), .i_tag({1'b0, o_csi1_last}), .o_ready(rdy1));
   //------------------------------------------------------------
   // Compare, bus and closing tasks
   //------------------------------------------------------------
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("BAD reg %h exp %h got %h", a, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk_reg(a, e, o_rd_data & m);
      @(posedge i_clk);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   //------------------------------------------------------------
   // Clock, watchdog and main sequence
   //------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      wrap_up();
   end
   initial begin
      {i_rst_n, i_wr, i_rd, slow0, slow1, multi} = '0;
      {i_addr, i_wr_data, i_rx_long, i_rx_end} = '0;
      {cnt0, cnt1, err_count, n_tests} = '0;
      rows = '{'{8'h20, 8'hFF, 8'h30}, '{8'h20, 8'hC0, 8'h00}, '{8'h21, 8'hFE, 8'hCC},
               '{8'h21, 8'h32, 8'h00}, '{8'h21, 8'h04, 8'h04}, '{8'h21, 8'h08, 8'h08},
               '{8'h21, 8'h0C, 8'h0C}, '{8'h21, 8'h80, 8'h80}, '{8'h21, 8'h40, 8'h40},
               '{8'h40, 8'hFF, 8'h00}, '{8'h21, 8'h01, 8'h01}};
      cyc(4);
      i_rst_n <= 1'b1;
      cyc(1);
      rd(ADDR_PORT_CTRL, 8'h30, 8'hFF);
      rd(ADDR_POLICY_CTRL, 8'h01, 8'hFF);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e, 8'hFF);
      end
      // Reset in mid-run restores both control registers
      wr(ADDR_POLICY_CTRL, 8'h0C);
      i_rst_n <= 1'b0;
      cyc(2);
      i_rst_n <= 1'b1;
      cyc(1);
      rd(ADDR_PORT_CTRL, 8'h30, 8'hFF);
      rd(ADDR_POLICY_CTRL, 8'h01, 8'hFF);
      wr(ADDR_PORT_CTRL, 8'h30);
      // Both ports off: nothing is taken
      cnt0 <= 2;
      cnt1 <= 2;
      cyc(20);
      chk_word("words out", 0, DW'(sink0.got.size()));
      // Only port 0 on, no waiting for port 1
      wr(ADDR_PORT_CTRL, 8'h20);
      cyc(20);
      chk_word("port0 word", 32'h0000_0002, sink0.got[0]);
      chk_word("words out", 2, DW'(sink0.got.size()));
      chk_word("port1 left", 2, DW'(cnt1));
      wr(ADDR_PORT_CTRL, 8'h00);
      cyc(20);
      // Round robin with a slow receiver
      sink0.got.delete();
      sink0.tag.delete();
      slow0 <= 1'b1;
      cnt0 <= 3;
      cnt1 <= 3;
      cyc(60);
      chk_word("words out", 6, DW'(sink0.got.size()));
      for (int i = 1; i < 6; i++) begin
         chk_word("rr turn", DW'(!sink0.got[i-1][16]), DW'(sink0.got[i][16]));
      end
      chk_word("csi1 idle", 0, DW'(sink1.got.size()));
      // Three-word packets: each is sent whole before the other port
      sink0.got.delete();
      sink0.tag.delete();
      multi <= 1'b1;
      cnt0 <= 3;
      cnt1 <= 3;
      cyc(60);
      multi <= 1'b0;
      chk_word("words out", 6, DW'(sink0.got.size()));
      for (int i = 0; i < 6; i++) begin
         chk_word("packet src", DW'((i > 2) ^ sink0.got[0][16]), DW'(sink0.got[i][16]));
         chk_word("packet last", DW'(i % 3 == 2), DW'(sink0.tag[i][0]));
      end
      // Replicate onto both CSI outputs, second receiver stalls
      wr(ADDR_POLICY_CTRL, 8'h81);
      sink0.got.delete();
      sink0.tag.delete();
      slow0 <= 1'b0;
      slow1 <= 1'b1;
      cnt0 <= 2;
      cnt1 <= 2;
      cyc(40);
      chk_word("copies", 4, DW'(sink1.got.size()));
      for (int i = 0; i < 4; i++) begin
         chk_word("copy", sink0.got[i], sink1.got[i]);
         chk_word("copy last", DW'(sink0.tag[i][0]), DW'(sink1.tag[i][0]));
      end
      // Basic synchronized: hold until both ports have a line
      wr(ADDR_POLICY_CTRL, 8'h04);
      sink0.got.delete();
      sink0.tag.delete();
      slow1 <= 1'b0;
      i_rx_long <= 2'h3;
      cnt0 <= 1;
      cyc(20);
      chk_word("held", 0, DW'(sink0.got.size()));
      rd(ADDR_FWD_STATUS, 8'h00, 8'h04);
      cnt1 <= 1;
      cyc(20);
      chk_word("group", 2, DW'(sink0.got.size()));
      chk_word("order", 32'h0001_0001, sink0.got[1]);
      chk_word("group tag", 32'h1, DW'(sink0.tag[0]));
      // As available: long lines go alone, short packets wait
      wr(ADDR_POLICY_CTRL, 8'h44);
      cnt0 <= 1;
      cyc(20);
      chk_word("alone", 3, DW'(sink0.got.size()));
      i_rx_long <= 2'h0;
      cnt0 <= 1;
      cyc(20);
      chk_word("short held", 3, DW'(sink0.got.size()));
      cnt1 <= 1;
      cyc(20);
      // Concatenation ignores the as-available bit
      wr(ADDR_POLICY_CTRL, 8'h4C);
      i_rx_long <= 2'h3;
      cnt0 <= 1;
      cyc(20);
      chk_word("concat held", 5, DW'(sink0.got.size()));
      cnt1 <= 1;
      cyc(20);
      chk_word("concat tag", 32'h0, DW'(sink0.tag[5]));
      chk_word("concat tag", 32'h3, DW'(sink0.tag[6]));
      // Frame end group, then an alignment loss and the interrupt
      wr(ADDR_POLICY_CTRL, 8'h04);
      wr(ADDR_IRQ_MASK, 8'h03);
      i_rx_long <= 2'h0;
      i_rx_end <= 2'h3;
      cnt0 <= 1;
      cnt1 <= 1;
      cyc(20);
      chk_word("irq", 1, DW'(o_irq));
      rd(ADDR_FWD_STATUS, 8'h01, 8'h05);
      i_rx_long <= 2'h3;
      i_rx_end <= 2'h0;
      cnt0 <= 1;
      cyc(30);
      cnt1 <= 1;
      cyc(20);
      rd(ADDR_FWD_STATUS, 8'h04, 8'h04);
      rd(ADDR_FWD_STATUS, 8'h00, 8'h04);
      rd(ADDR_IRQ_STATUS, 8'h03, 8'h03);
      wr(ADDR_IRQ_MASK, 8'h00);
      cyc(2);
      chk_word("irq masked", 0, DW'(o_irq));
      wr(ADDR_IRQ_STATUS, 8'h03);
      rd(ADDR_IRQ_STATUS, 8'h00, 8'h03);
      wr(ADDR_IRQ_MASK, 8'h03);
      cyc(2);
      chk_word("irq cleared", 0, DW'(o_irq));
      wrap_up();
   end
endmodule // tb
`default_nettype wire
